// ---- nfu_consts.vh ----
`ifndef NFU_CONSTS_VH
`define NFU_CONSTS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_W           4
`define OP_NOP         4'h0
`define OP_FX16_CHECK  4'h1
`define OP_FX32_CHECK  4'h2
`define OP_FX16_DIV    4'h3
`define OP_FX32_DIV    4'h4
`define OP_BCD_TO_FX   4'h5
`define OP_FX_TO_BCD   4'h6
`define OP_FX_TO_FP    4'h7
`define OP_FP_TO_FX    4'h8
`define OP_FP_CHECK    4'h9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FX16_SIGN      15
`define FX32_SIGN      31
`define FP_MANT_MSB    23
`define FP_MANT_LSB    0
`define FP_EXP_MSB     31
`define FP_EXP_LSB     24
`define BCD_SIGN_MSB   15
`define BCD_SIGN_LSB   12

// ----------------------------------------
// Constant codes
// ----------------------------------------
`define FX16_MIN       32'hFFFF8000
`define FX16_MAX       32'h00007FFF
`define FX32_MIN       32'h80000000
`define FX32_MAX       32'h7FFFFFFF
`define FP_ZERO        32'h80000000
`define BCD_POS        4'h0
`define BCD_NEG        4'hF
`define BCD_DIGIT_MAX  4'h9
`define BCD_MAG_MAX    32'h000003E7

// ----------------------------------------
// Timing
// ----------------------------------------
`define DIV_STEPS      32

`endif

// ---- nfu_divider.v ----
`timescale 1ns/1ps
`include "nfu_consts.vh"

// ----------------------------------------
// Signed restoring divider, truncating
// ----------------------------------------
module nfu_divider #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             en_i,
    // Request
    input  wire             start_i,
    input  wire [WIDTH-1:0] dividend_i,
    input  wire [WIDTH-1:0] divisor_i,
    // Answer
    output reg              busy_o,
    output reg              done_o,
    output reg  [WIDTH-1:0] quot_o,
    output reg              div_zero_o
);
    reg  [WIDTH-1:0] rem_q;
    reg  [WIDTH-1:0] acc_q;
    reg  [WIDTH-1:0] dsr_q;
    reg              neg_q;
    reg  [6:0]       cnt_q;
    wire [WIDTH:0]   trial;

    localparam [6:0] STEPS = WIDTH;

    assign trial = {rem_q, acc_q[WIDTH-1]} - {1'b0, dsr_q};

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rem_q      <= {WIDTH{1'b0}};
            acc_q      <= {WIDTH{1'b0}};
            dsr_q      <= {WIDTH{1'b0}};
            neg_q      <= 1'b0;
            cnt_q      <= 7'h00;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
            quot_o     <= {WIDTH{1'b0}};
            div_zero_o <= 1'b0;
        end else if (en_i) begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                rem_q      <= {WIDTH{1'b0}};
                acc_q      <= dividend_i[WIDTH-1] ? (~dividend_i + 1'b1) : dividend_i;
                dsr_q      <= divisor_i[WIDTH-1] ? (~divisor_i + 1'b1) : divisor_i;
                neg_q      <= dividend_i[WIDTH-1] ^ divisor_i[WIDTH-1];
                div_zero_o <= (divisor_i == {WIDTH{1'b0}});
                cnt_q      <= STEPS;
                busy_o     <= 1'b1;
            end else if (busy_o) begin
                if (!trial[WIDTH]) begin
                    rem_q <= trial[WIDTH-1:0];
                    acc_q <= {acc_q[WIDTH-2:0], 1'b1};
                end else begin
                    rem_q <= {rem_q[WIDTH-2:0], acc_q[WIDTH-1]};
                    acc_q <= {acc_q[WIDTH-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 7'h01;
                if (cnt_q == 7'h01) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end else if (done_o == 1'b0 && cnt_q == 7'h00) begin
                cnt_q <= 7'h00;
            end
            if (busy_o && cnt_q == 7'h01) begin
                // Quotient magnitude truncated toward zero, sign restored
                quot_o <= neg_q ? (~(trial[WIDTH] ? {acc_q[WIDTH-2:0], 1'b0} : {acc_q[WIDTH-2:0], 1'b1}) + 1'b1)
                                : (trial[WIDTH] ? {acc_q[WIDTH-2:0], 1'b0} : {acc_q[WIDTH-2:0], 1'b1});
            end
        end
    end
endmodule

// ---- plc_number_format_unit.v ----
`timescale 1ns/1ps
`include "nfu_consts.vh"

module plc_number_format_unit #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_n_i,
    input  wire             en_i,
    // Request
    input  wire             start_i,
    input  wire [3:0]       op_i,
    input  wire [WIDTH-1:0] accu1_i,
    input  wire [WIDTH-1:0] accu2_i,
    // Answer
    output wire             busy_o,
    output reg              done_o,
    output reg  [WIDTH-1:0] result_o,
    output reg              range_err_o,
    output reg              digit_err_o,
    output reg              div_zero_o,
    output reg              is_neg_o,
    output reg              is_zero_o,
    output reg              mag_ge_tenth_o
);
    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function digit_bad;
        input [3:0] d;
        begin
            digit_bad = (d > `BCD_DIGIT_MAX);
        end
    endfunction

    function [31:0] abs32;
        input [31:0] v;
        begin
            abs32 = v[`FX32_SIGN] ? (~v + 32'h00000001) : v;
        end
    endfunction

    function [3:0] bin_digit;
        input [31:0] v;
        input [1:0]  pos;
        reg   [31:0] t;
        begin
            t = (pos == 2'd2) ? v / 32'd100 : (pos == 2'd1) ? v / 32'd10 : v;
            t = t % 32'd10;
            bin_digit = t[3:0];
        end
    endfunction

    // ----------------------------------------
    // Combinational encode / decode
    // ----------------------------------------
    localparam S_IDLE = 3'b001;
    localparam S_DIV  = 3'b010;
    localparam S_OUT  = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [31:0] res_c;
    reg         rng_c;
    reg         dig_c;
    reg         neg_c;
    reg         zero_c;
    reg         tenth_c;
    reg  [31:0] mag;
    reg  [31:0] bcd_mag;
    reg  [31:0] sext_a;
    reg  [31:0] sext_b;
    reg  [31:0] mant_x;
    reg  [7:0]  ex;
    reg  [5:0]  sh;
    integer     i;

    wire        dv_done;
    wire [31:0] dv_quot;
    wire        dv_zero;
    wire        dv_busy;
    wire        dv_start;
    wire        is_div;

    assign is_div   = (op_i == `OP_FX16_DIV) || (op_i == `OP_FX32_DIV);
    assign dv_start = start_i && (state_q == S_IDLE) && !dv_busy && is_div;
    assign busy_o   = (state_q != S_IDLE);

    always @* begin
        res_c   = 32'h00000000;
        rng_c   = 1'b0;
        dig_c   = 1'b0;
        neg_c   = 1'b0;
        zero_c  = 1'b0;
        tenth_c = 1'b0;
        mag     = 32'h00000000;
        bcd_mag = 32'h00000000;
        mant_x  = 32'h00000000;
        ex      = 8'h00;
        sh      = 6'd0;
        i       = 0;
        sext_a  = {{16{accu1_i[`FX16_SIGN]}}, accu1_i[15:0]};
        sext_b  = {{16{accu2_i[`FX16_SIGN]}}, accu2_i[15:0]};
        case (op_i)
            `OP_FX16_CHECK: begin
                neg_c  = accu1_i[`FX32_SIGN];
                res_c  = accu1_i;
                // Outside the word range when high half is not sign extension
                rng_c  = ($signed(accu1_i) < $signed(`FX16_MIN)) || ($signed(accu1_i) > $signed(`FX16_MAX));
                zero_c = (accu1_i == 32'h00000000);
            end
            `OP_FX32_CHECK: begin
                neg_c  = accu1_i[`FX32_SIGN];
                res_c  = accu1_i;
                zero_c = (accu1_i == 32'h00000000);
            end
            `OP_BCD_TO_FX: begin
                dig_c = digit_bad(accu1_i[11:8]) | digit_bad(accu1_i[7:4]) | digit_bad(accu1_i[3:0]);
                dig_c = dig_c | ((accu1_i[15:12] != `BCD_POS) && (accu1_i[15:12] != `BCD_NEG));
                bcd_mag = accu1_i[11:8] * 32'd100 + accu1_i[7:4] * 32'd10 + {28'h0000000, accu1_i[3:0]};
                neg_c  = (accu1_i[`BCD_SIGN_MSB:`BCD_SIGN_LSB] == `BCD_NEG);
                res_c  = neg_c ? (~bcd_mag + 32'h00000001) : bcd_mag;
                zero_c = (bcd_mag == 32'h00000000);
            end
            `OP_FX_TO_BCD: begin
                neg_c  = accu1_i[`FX32_SIGN];
                mag    = abs32(accu1_i);
                rng_c  = (mag > `BCD_MAG_MAX);
                res_c  = {16'h0000, neg_c ? `BCD_NEG : `BCD_POS, bin_digit(mag, 2'd2),
                          bin_digit(mag, 2'd1), bin_digit(mag, 2'd0)};
                if (rng_c)
                    res_c = accu1_i;
                zero_c = (mag == 32'h00000000);
            end
            `OP_FX_TO_FP: begin
                // 24-bit mantissa, exponent as power of two
                neg_c  = accu1_i[`FX32_SIGN];
                zero_c = (accu1_i == 32'h00000000);
                mag    = abs32(accu1_i);
                sh     = 6'd0;
                for (i = 0; i < 9; i = i + 1) begin
                    if (mag > 32'h007FFFFF) begin
                        mag = mag >> 1;
                        sh  = sh + 6'd1;
                    end
                end
                mant_x = neg_c ? (~mag + 32'h00000001) : mag;
                res_c  = zero_c ? `FP_ZERO : {2'b00, sh, mant_x[`FP_MANT_MSB:`FP_MANT_LSB]};
                tenth_c = !zero_c;
            end
            `OP_FP_TO_FX, `OP_FP_CHECK: begin
                zero_c = (accu1_i == `FP_ZERO);
                ex     = accu1_i[`FP_EXP_MSB:`FP_EXP_LSB];
                mant_x = {{8{accu1_i[`FP_MANT_MSB]}}, accu1_i[`FP_MANT_MSB:`FP_MANT_LSB]};
                neg_c  = !zero_c && accu1_i[`FP_MANT_MSB];
                tenth_c = !zero_c && !ex[7];
                if (op_i == `OP_FP_CHECK) begin
                    res_c = accu1_i;
                end else if (zero_c) begin
                    res_c = 32'h00000000;
                end else if (ex[7]) begin
                    sh    = (ex > 8'hE0) ? (6'd0 - ex[5:0]) : 6'd31;
                    res_c = $signed(mant_x) >>> sh;
                end else begin
                    rng_c = (ex > 8'h07);
                    res_c = rng_c ? (neg_c ? `FX32_MIN : `FX32_MAX) : (mant_x << ex[2:0]);
                end
            end
            default: begin
                res_c = accu1_i;
            end
        endcase
    end

    // ----------------------------------------
    // Divider
    // ----------------------------------------
    nfu_divider #(
        .WIDTH      (32)
    ) u_div (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .en_i       (en_i),
        .start_i    (dv_start),
        .dividend_i ((op_i == `OP_FX16_DIV) ? sext_a : accu1_i),
        .divisor_i  ((op_i == `OP_FX16_DIV) ? sext_b : accu2_i),
        .busy_o     (dv_busy),
        .done_o     (dv_done),
        .quot_o     (dv_quot),
        .div_zero_o (dv_zero)
    );

    reg div16_q;

    // ----------------------------------------
    // Control
    // ----------------------------------------
    always @* begin
        case (state_q)
            S_IDLE:  state_d = dv_start ? S_DIV : (start_i ? S_OUT : S_IDLE);
            S_DIV:   state_d = dv_done ? S_IDLE : S_DIV;
            S_OUT:   state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q        <= S_IDLE;
            div16_q        <= 1'b0;
            done_o         <= 1'b0;
            result_o       <= 32'h00000000;
            range_err_o    <= 1'b0;
            digit_err_o    <= 1'b0;
            div_zero_o     <= 1'b0;
            is_neg_o       <= 1'b0;
            is_zero_o      <= 1'b0;
            mag_ge_tenth_o <= 1'b0;
        end else if (en_i) begin
            state_q <= state_d;
            done_o  <= 1'b0;
            if (dv_start)
                div16_q <= (op_i == `OP_FX16_DIV);
            if (state_q == S_IDLE && start_i && !is_div) begin
                done_o         <= 1'b1;
                result_o       <= res_c;
                range_err_o    <= rng_c;
                digit_err_o    <= dig_c;
                div_zero_o     <= 1'b0;
                is_neg_o       <= neg_c;
                is_zero_o      <= zero_c;
                mag_ge_tenth_o <= tenth_c;
            end
            if (state_q == S_DIV && dv_done) begin
                done_o         <= 1'b1;
                result_o       <= dv_quot;
                div_zero_o     <= dv_zero;
                range_err_o    <= div16_q && (($signed(dv_quot) < $signed(`FX16_MIN)) ||
                                              ($signed(dv_quot) > $signed(`FX16_MAX)));
                digit_err_o    <= 1'b0;
                is_neg_o       <= dv_quot[`FX32_SIGN];
                is_zero_o      <= (dv_quot == 32'h00000000);
                mag_ge_tenth_o <= 1'b0;
            end
        end
    end
endmodule

// ---- plc_nfu_chk.sv ----
`timescale 1ns/1ps
`include "nfu_consts.vh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module nfu_chk #(
    parameter WIDTH = 32
) (
    // Clock and reset
    input logic             clk_i,
    input logic             rst_n_i,
    input logic             en_i,
    // Request
    input logic             start_i,
    input logic [3:0]       op_i,
    input logic [WIDTH-1:0] accu1_i,
    input logic [WIDTH-1:0] accu2_i,
    // Answer
    input logic             busy_o,
    input logic             done_o,
    input logic [WIDTH-1:0] result_o,
    input logic             range_err_o,
    input logic             digit_err_o,
    input logic             div_zero_o,
    input logic             is_neg_o,
    input logic             is_zero_o,
    input logic             mag_ge_tenth_o
);
    logic [3:0]       op_q;
    logic [WIDTH-1:0] a_q;
    logic             take;
    logic             bad;

    assign take = en_i && start_i && !busy_o;
    assign bad = (a_q[15:12] != 4'h0 && a_q[15:12] != 4'hF) || a_q[11:8] > 4'h9
                 || a_q[7:4] > 4'h9 || a_q[3:0] > 4'h9;

    // Request capture
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q <= 4'h0;
            a_q <= '0;
        end else if (take) begin
            op_q <= op_i;
            a_q <= accu1_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_TAKE_BUSY: assert property (take |=> busy_o)
        else $error("busy not raised after take");
    AST_DONE_PULSE: assert property (done_o && en_i |=> !done_o)
        else $error("done longer than one cycle");
    AST_FREEZE: assert property (!en_i |=> $stable(result_o) && $stable(done_o) && $stable(busy_o))
        else $error("state moved with enable low");
    AST_FX32_SIGN: assert property (done_o && op_q == `OP_FX32_CHECK |-> is_neg_o == a_q[31] && !range_err_o)
        else $error("double word sign or range wrong");
    AST_FP_ZERO_OUT: assert property (done_o && op_q == `OP_FX_TO_FP |-> (result_o == `FP_ZERO) == (a_q == 0))
        else $error("float zero code wrong");
    AST_FP_ZERO_IN: assert property (done_o && op_q == `OP_FP_CHECK |-> is_zero_o == (a_q == `FP_ZERO))
        else $error("float zero not recognised");
    AST_FP_WORD: assert property (done_o && op_q == `OP_FP_CHECK |-> result_o == a_q)
        else $error("float double word not kept whole");
    AST_FP_EXP_SIGN: assert property (done_o && op_q == `OP_FP_CHECK && !is_zero_o |-> mag_ge_tenth_o == !a_q[31])
        else $error("exponent sign misread");
    AST_FP_MANT_SIGN: assert property (done_o && op_q == `OP_FP_CHECK && !is_zero_o |-> is_neg_o == a_q[23])
        else $error("mantissa sign misread");
    AST_BCD_DIGITS: assert property (done_o && op_q == `OP_BCD_TO_FX |-> digit_err_o == bad)
        else $error("digit error flag wrong");
    AST_BCD_SIGN: assert property (done_o && op_q == `OP_FX_TO_BCD && !range_err_o
                                   |-> result_o[15:12] == (is_neg_o ? 4'hF : 4'h0))
        else $error("decimal sign nibble wrong");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    COV_DIV: cover property (done_o && op_q == `OP_FX32_DIV);
    COV_RANGE: cover property (done_o && range_err_o);
    COV_STALL: cover property (busy_o && !en_i);
endmodule

bind plc_number_format_unit nfu_chk #(.WIDTH(WIDTH)) i_nfu_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .start_i(start_i), .op_i(op_i),
    .accu1_i(accu1_i), .accu2_i(accu2_i), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o), .range_err_o(range_err_o), .digit_err_o(digit_err_o),
    .div_zero_o(div_zero_o), .is_neg_o(is_neg_o), .is_zero_o(is_zero_o),
    .mag_ge_tenth_o(mag_ge_tenth_o)
);

// ---- plc_number_format_unit_tb_top.sv ----
`timescale 1ns/1ps
`include "nfu_consts.vh"

module plc_number_format_unit_tb_top;
    logic        clk_i = 1'h0;
    logic        rst_n_i = 1'h0;
    logic        en_i = 1'h1;
    logic        start_i = 1'h0;
    logic [3:0]  op_i = 4'h0;
    logic [31:0] accu1_i = 32'h0;
    logic [31:0] accu2_i = 32'h0;
    wire         busy_o, done_o, range_err_o, digit_err_o;
    wire         div_zero_o, is_neg_o, is_zero_o, mag_ge_tenth_o;
    wire  [31:0] result_o;
    int          mismatches = 0;
    int          compares = 0;

    always #2.5 clk_i = ~clk_i;

    plc_number_format_unit #(.WIDTH(32)) i_plc_number_format_unit (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .start_i(start_i), .op_i(op_i),
        .accu1_i(accu1_i), .accu2_i(accu2_i), .busy_o(busy_o), .done_o(done_o),
        .result_o(result_o), .range_err_o(range_err_o), .digit_err_o(digit_err_o),
        .div_zero_o(div_zero_o), .is_neg_o(is_neg_o), .is_zero_o(is_zero_o),
        .mag_ge_tenth_o(mag_ge_tenth_o)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cw(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cf(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic issue(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
        @(negedge clk_i);
        start_i = 1'h1;
        op_i = op;
        accu1_i = a;
        accu2_i = b;
        @(negedge clk_i);
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done_o !== 1'h1 && n < 60) begin
            @(negedge clk_i);
            n++;
        end
        cf(done_o, 1'h1);
    endtask

    task automatic go(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
        issue(op, a, b);
        start_i = 1'h0;
        wait_done();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_fixed();
        go(`OP_FX16_CHECK, 32'h00007FFF, 32'h0);
        cf(is_neg_o, 1'h0);
        cf(range_err_o, 1'h0);
        go(`OP_FX16_CHECK, 32'hFFFF8000, 32'h0);
        cf(is_neg_o, 1'h1);
        cf(range_err_o, 1'h0);
        go(`OP_FX32_CHECK, 32'h80000000, 32'h0);
        cf(is_neg_o, 1'h1);
        go(`OP_FX32_CHECK, 32'h7FFFFFFF, 32'h0);
        cf(is_neg_o, 1'h0);
    endtask

    task automatic t_div();
        go(`OP_FX32_DIV, 32'hFFFFFFF9, 32'h00000002);
        cw(result_o, 32'hFFFFFFFD);
        cf(div_zero_o, 1'h0);
        go(`OP_FX16_DIV, 32'h00000007, 32'h0000FFFE);
        cw({16'h0, result_o[15:0]}, 32'h0000FFFD);
        go(`OP_FX16_DIV, 32'h00008000, 32'h0000FFFF);
        cf(range_err_o, 1'h1);
        go(`OP_FX32_DIV, 32'h00000009, 32'h0);
        cf(div_zero_o, 1'h1);
    endtask

    task automatic t_stall();
        issue(`OP_FX32_DIV, 32'h00000064, 32'hFFFFFFF9);
        op_i = `OP_FX_TO_FP;
        repeat (3) @(negedge clk_i);
        start_i = 1'h0;
        en_i = 1'h0;
        repeat (40) @(negedge clk_i);
        cf(done_o, 1'h0);
        cf(busy_o, 1'h1);
        en_i = 1'h1;
        wait_done();
        cw(result_o, 32'hFFFFFFF2);
        @(negedge clk_i);
        cf(done_o, 1'h0);
    endtask

    task automatic t_bcd();
        go(`OP_BCD_TO_FX, 32'h0000F123, 32'h0);
        cw(result_o, 32'hFFFFFF85);
        cf(digit_err_o, 1'h0);
        go(`OP_BCD_TO_FX, 32'h00000999, 32'h0);
        cw(result_o, 32'h000003E7);
        go(`OP_BCD_TO_FX, 32'h00000A00, 32'h0);
        cf(digit_err_o, 1'h1);
        go(`OP_BCD_TO_FX, 32'h00005123, 32'h0);
        cf(digit_err_o, 1'h1);
        go(`OP_FX_TO_BCD, 32'hFFFFFC19, 32'h0);
        cw({16'h0, result_o[15:0]}, 32'h0000F999);
        go(`OP_FX_TO_BCD, 32'h00000309, 32'h0);
        cw({16'h0, result_o[15:0]}, 32'h00000777);
        go(`OP_FX_TO_BCD, 32'h000003E8, 32'h0);
        cf(range_err_o, 1'h1);
        go(`OP_FX_TO_BCD, 32'hFFFFFC18, 32'h0);
        cf(range_err_o, 1'h1);
    endtask

    task automatic t_fp();
        go(`OP_FX_TO_FP, 32'h0, 32'h0);
        cw(result_o, 32'h80000000);
        go(`OP_FX_TO_FP, 32'h00000005, 32'h0);
        cw(result_o, 32'h00000005);
        go(`OP_FP_TO_FX, 32'h80000000, 32'h0);
        cw(result_o, 32'h0);
        cf(is_zero_o, 1'h1);
        go(`OP_FP_TO_FX, 32'h02000003, 32'h0);
        cw(result_o, 32'h0000000C);
        go(`OP_FP_TO_FX, 32'hFFFFFFFD, 32'h0);
        cw(result_o, 32'hFFFFFFFE);
        go(`OP_FP_TO_FX, 32'h08000001, 32'h0);
        cf(range_err_o, 1'h1);
        go(`OP_FP_CHECK, 32'h80000000, 32'h0);
        cf(mag_ge_tenth_o, 1'h0);
        go(`OP_FP_CHECK, 32'hFE000004, 32'h0);
        cf(mag_ge_tenth_o, 1'h0);
        go(`OP_FP_CHECK, 32'h01FFFFFF, 32'h0);
        cf(is_neg_o, 1'h1);
        cf(mag_ge_tenth_o, 1'h1);
    endtask

    task automatic t_reset();
        issue(`OP_FX32_DIV, 32'h00000064, 32'h00000003);
        start_i = 1'h0;
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'h0;
        #1;
        cf(busy_o, 1'h0);
        cw(result_o, 32'h0);
        @(negedge clk_i);
        rst_n_i = 1'h1;
        go(`OP_FX_TO_FP, 32'h00000005, 32'h0);
        cw(result_o, 32'h00000005);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(negedge clk_i);
        rst_n_i = 1'h1;
        t_fixed();
        t_div();
        t_stall();
        t_bcd();
        t_fp();
        t_reset();
        results();
    end

    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule
